// >>> dsee_decoder.sv
// Data-space decoder: one select per mapped address.
`default_nettype none

module dsee_decoder
  import dsee_pkg::*;
(
  input  wire logic [15:0]      addr,
  output logic      [SEL_W-1:0] sel,
  output logic      [11:0]      sram_ofs
);

  logic [15:0] diff;

  always_comb begin
    diff     = addr - SRAM_BASE;
    sram_ofs = diff[11:0];
    sel      = '0;
    if (addr < STDIO_BASE) begin
      sel[SEL_RF] = 1'b1;
    end else if (addr < EXTIO_BASE) begin
      sel[SEL_STDIO] = 1'b1;
    end else if (addr < SRAM_BASE) begin
      sel[SEL_EXTIO] = 1'b1;
    end else if (addr < SRAM_END) begin
      sel[SEL_SRAM] = 1'b1;
    end
  end

endmodule // dsee_decoder

`default_nettype wire

// >>> dsee_ext_model.sv
// Behavioural model of the outside registers behind the external access port.
`default_nettype none
module dsee_ext_model (
  input  wire logic       clk,
  input  wire logic       ext_re_q,
  input  wire logic       ext_we_q,
  input  wire logic [7:0] ext_addr_q,
  input  wire logic [7:0] ext_wdata_q,
  input  wire logic [7:0] ext_wmask_q,
  output logic      [7:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  // ********************************************************************
  // Targets
  // ********************************************************************
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h2E] = 8'h80;
    ext_rdata = 8'h00;
  end
  // Data holds only after a read strobe; it toggles otherwise.
  always @(posedge clk) begin
    ext_rdata <= ext_re_q ? mem[ext_addr_q] : ~ext_rdata;
    if (ext_we_q) begin
      mem[ext_addr_q] <= (mem[ext_addr_q] & ~ext_wmask_q) | (ext_wdata_q & ext_wmask_q);
      if (ext_addr_q == 8'h2E)
        mem[8'h2E][7] <= mem[8'h2E][7] & ~(ext_wdata_q[7] & ext_wmask_q[7]);
    end
  end
endmodule // dsee_ext_model
`default_nettype wire

// >>> dsee_mem.sv
// Single-port byte memory with registered read data.
`default_nettype none

module dsee_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);

  // No reset: contents survive a system reset.
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[addr];
    end
  end

endmodule // dsee_mem

`default_nettype wire

// >>> dsee_pkg.sv
// Constants, types and functions for the decode and EEPROM port.
`default_nettype none

package dsee_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int  CLK_NS    = 40;
  localparam real T_EW_MS   = 3.4;
  localparam real T_ERW_MS  = 1.8;
  localparam real NS_PER_MS = 1.0e6;
  localparam real ROUND_EPS = 1.0e-6;
  // Programming times are minimums, so counts round up.
  localparam int  EW_CYC    = int'($ceil(T_EW_MS * NS_PER_MS / CLK_NS - ROUND_EPS));
  localparam int  ERW_CYC   = int'($ceil(T_ERW_MS * NS_PER_MS / CLK_NS - ROUND_EPS));
  localparam logic [2:0] ARM_CYC  = 3'h4;
  localparam logic [2:0] RD_STALL = 3'h4;
  localparam logic [2:0] WR_STALL = 3'h2;

  // ********************************************************************
  // Data-space map
  // ********************************************************************
  localparam logic [15:0] STDIO_BASE  = 16'h0020;
  localparam logic [15:0] EXTIO_BASE  = 16'h0060;
  localparam logic [15:0] SRAM_BASE   = 16'h0100;
  localparam logic [15:0] SRAM_END    = 16'h1100;
  localparam logic [15:0] IO_DATA_OFS = 16'h0020;
  localparam logic [15:0] PTR_STEP    = 16'h0001;
  localparam logic [4:0]  RF_PTR_FIRST = 5'h1A;
  localparam int SEL_W     = 4;
  localparam int SEL_RF    = 0;
  localparam int SEL_STDIO = 1;
  localparam int SEL_EXTIO = 2;
  localparam int SEL_SRAM  = 3;
  localparam int SRAM_AW   = 12;
  localparam int EE_AW     = 12;

  // ********************************************************************
  // EEPROM access registers (data-space addresses)
  // ********************************************************************
  localparam logic [15:0] EE_CTL_DA  = 16'h001F + IO_DATA_OFS;
  localparam logic [15:0] EE_DATA_DA = 16'h0020 + IO_DATA_OFS;
  localparam logic [15:0] EE_ADRL_DA = 16'h0021 + IO_DATA_OFS;
  localparam logic [15:0] EE_ADRH_DA = 16'h0022 + IO_DATA_OFS;
  localparam int CTL_RD_BIT  = 0;
  localparam int CTL_WR_BIT  = 1;
  localparam int CTL_ARM_BIT = 2;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_MODE_HI = 5;
  localparam logic [7:0] BYTE_FULL = 8'hFF;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [1:0] PTR_X     = 2'h0;
  localparam logic [1:0] PTR_Z     = 2'h2;

  typedef enum logic [1:0] {
    MODE_EW    = 2'b00,
    MODE_ERASE = 2'b01,
    MODE_WRITE = 2'b10,
    MODE_RSVD  = 2'b11
  } dsee_pmode_t;

  typedef enum logic [2:0] {
    OP_LOAD    = 3'h0,
    OP_STORE   = 3'h1,
    OP_IN      = 3'h2,
    OP_OUT     = 3'h3,
    OP_SETBIT  = 3'h4,
    OP_CLRBIT  = 3'h5,
    OP_SKIPSET = 3'h6,
    OP_SKIPCLR = 3'h7
  } dsee_op_t;

  typedef enum logic [2:0] {
    AM_DIRECT  = 3'h0,
    AM_INDIR   = 3'h1,
    AM_DISP    = 3'h2,
    AM_PREDEC  = 3'h3,
    AM_POSTINC = 3'h4
  } dsee_amode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FIN   = 2'b11,
    ST_STALL = 2'b10
  } dsee_state_t;

  // ********************************************************************
  // Functions
  // ********************************************************************
  function automatic logic [7:0] merge_byte(logic [7:0] old, logic [7:0] d, logic [7:0] m);
    return (old & ~m) | (d & m);
  endfunction

  function automatic logic [7:0] bit_mask(logic [2:0] b);
    return 8'h01 << b;
  endfunction

  function automatic logic op_writes(dsee_op_t op);
    return (op == OP_STORE) || (op == OP_OUT) || (op == OP_SETBIT) || (op == OP_CLRBIT);
  endfunction

endpackage

`default_nettype wire

// >>> dsee_port.sv
// Decoder, pointers, program counter and EEPROM port.
//
// Functional notes
// - SRAM access takes two cycles.
// - Map: 32 registers, 64 I/O, 160 extended I/O.
// - Next 4096 addresses are SRAM.
// - In/out never reach extended I/O.
// - Bit ops and skips use I/O 0x00-0x1F.
// - In/out use I/O 0x00-0x3F; data space adds 0x20.
// - Bit set/clear writes only its bit.
// - Some flags clear on writing one.
// - Displacement adds 0..63 to Y or Z.
// - Pre-decrement before access, post-increment after.
// - Registers 26-31 are pointers X, Y, Z.
// - EEPROM read stalls four cycles.
// - EEPROM write start stalls two cycles.
// - Writes are self-timed with a busy flag.
// - A write survives a system reset.
// - EEPROM is a separate 4K byte space.
// - Writes need arm then strobe.
// - Address bits 15-12 read zero.
// - Address bits 11-0 pick the byte.
// - Address resets to zero on a system reset; load it first.
// - Program counter is 16 bits, word addressed.
// - Arm clears after four cycles; strobe needs arm.
// - Strobe clears when the write ends; it is busy.
// - Mode: erase-write, erase, write; 11 reserved.
// - During a write, reads and address writes are ignored.
`default_nettype none

module dsee_port
  import dsee_pkg::*;
#(
  parameter int EW_CYCLES  = EW_CYC,
  parameter int ERW_CYCLES = ERW_CYC
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             por_n,
  input  wire logic             req,
  input  wire logic [2:0]       req_op,
  input  wire logic [2:0]       req_mode,
  input  wire logic [1:0]       req_ptr,
  input  wire logic [15:0]      req_addr,
  input  wire logic [5:0]       req_disp,
  input  wire logic [5:0]       req_io,
  input  wire logic [2:0]       req_bit,
  input  wire logic [7:0]       req_wdata,
  input  wire logic [7:0]       ext_rdata,
  input  wire logic             pc_step,
  input  wire logic             pc_load,
  input  wire logic [15:0]      pc_target,
  output logic                  busy_q,
  output logic                  done_q,
  output logic      [7:0]       rdata_q,
  output logic                  skip_q,
  output logic      [SEL_W-1:0] sel_q,
  output logic                  ext_re_q,
  output logic                  ext_we_q,
  output logic      [7:0]       ext_addr_q,
  output logic      [7:0]       ext_wdata_q,
  output logic      [7:0]       ext_wmask_q,
  output logic                  nv_write_strobe_q,
  output logic      [15:0]      program_counter_q
);

  // ******************************************************************
  // State
  // ******************************************************************
  localparam int CYC_MAX = (EW_CYCLES > ERW_CYCLES) ? EW_CYCLES : ERW_CYCLES;
  localparam int TW      = $clog2(CYC_MAX + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(1);

  typedef struct packed {
    dsee_state_t      st;
    dsee_op_t         op;
    logic [SEL_W-1:0] sel;
    logic             intern;
    logic [15:0]      addr;
    logic [11:0]      sofs;
    logic [7:0]       wdata;
    logic [7:0]       wmask;
    logic [2:0]       stall;
    logic [7:0]       rdata;
    logic             skip;
    logic             done;
    logic             busy;
    logic             ext_re;
    logic             ext_we;
    logic [2:0][15:0] ptr;
    logic             arm;
    logic [2:0]       arm_cnt;
    logic [11:0]      eeadr;
    logic [7:0]       eedata;
    logic             rd_pend;
    logic [15:0]      pc;
  } dsee_core_t;

  // The write engine runs on the power-on reset only, so a system reset
  // cannot cut a programming cycle short and leave a half-written cell.
  typedef struct packed {
    logic          busy;
    logic [TW-1:0] timer;
    dsee_pmode_t   mode;
    logic [11:0]   waddr;
    logic [7:0]    wdata;
  } dsee_eng_t;

  dsee_core_t       core_q;
  dsee_core_t       core_d;
  dsee_eng_t        eng_q;
  dsee_eng_t        eng_d;
  logic [1:0]       pidx;
  logic [15:0]      pval;
  logic [15:0]      eff_addr;
  logic [SEL_W-1:0] dec_sel;
  logic [11:0]      dec_ofs;
  logic [7:0]       sram_rdata;
  logic             sram_we;
  logic [7:0]       ee_rdata;
  logic [11:0]      ee_addr;
  logic             ee_we;
  logic [7:0]       ee_wbyte;
  logic             ctl_wr;
  logic [7:0]       ctl_data;
  logic [7:0]       ctl_mask;
  logic             ee_start;
  logic             is_wr;
  logic             hit_int;
  logic [7:0]       mask;
  logic [7:0]       rd_val;
  logic [7:0]       ctl_rd;
  logic [2:0]       ridx;
  logic [7:0]       hi_byte;
  dsee_op_t         op_in;
  dsee_amode_t      am_in;

  // ******************************************************************
  // Effective address
  // ******************************************************************
  assign op_in = dsee_op_t'(req_op);
  assign am_in = dsee_amode_t'(req_mode);
  assign pidx  = (req_ptr > PTR_Z) ? PTR_Z : req_ptr;
  assign pval  = core_q.ptr[pidx];

  always_comb begin
    eff_addr = req_addr;
    unique case (op_in)
      OP_IN, OP_OUT: begin
        eff_addr = {10'h000, req_io} + IO_DATA_OFS;
      end
      OP_SETBIT, OP_CLRBIT, OP_SKIPSET, OP_SKIPCLR: begin
        eff_addr = {11'h000, req_io[4:0]} + IO_DATA_OFS;
      end
      OP_LOAD, OP_STORE: begin
        unique case (am_in)
          AM_DIRECT:  eff_addr = req_addr;
          AM_INDIR:   eff_addr = pval;
          AM_POSTINC: eff_addr = pval;
          AM_DISP:    eff_addr = (req_ptr == PTR_X) ? pval : pval + {10'h000, req_disp};
          AM_PREDEC:  eff_addr = pval - PTR_STEP;
          default:    eff_addr = req_addr;
        endcase
      end
    endcase
  end

  dsee_decoder u_dec (
    .addr     (eff_addr),
    .sel      (dec_sel),
    .sram_ofs (dec_ofs)
  );

  // ******************************************************************
  // Access sequencer
  // ******************************************************************
  always_comb begin
    core_d   = core_q;
    core_d.done   = 1'b0;
    core_d.ext_re = 1'b0;
    core_d.ext_we = 1'b0;
    ctl_wr   = 1'b0;
    ctl_data = '0;
    ctl_mask = '0;
    ee_start = 1'b0;
    is_wr    = op_writes(op_in);
    hit_int  = ((eff_addr[15:5] == '0) && (eff_addr[4:0] >= RF_PTR_FIRST)) ||
               (eff_addr == EE_CTL_DA) || (eff_addr == EE_DATA_DA) ||
               (eff_addr == EE_ADRL_DA) || (eff_addr == EE_ADRH_DA);
    mask     = bit_mask(req_bit);
    ridx     = core_q.addr[2:0] - RF_PTR_FIRST[2:0];
    hi_byte  = merge_byte({4'h0, core_q.eeadr[11:8]}, core_q.wdata, core_q.wmask);
    ctl_rd   = '0;
    ctl_rd[CTL_MODE_HI:CTL_MODE_LO] = eng_q.mode;
    ctl_rd[CTL_ARM_BIT] = core_q.arm;
    ctl_rd[CTL_WR_BIT]  = eng_q.busy;
    rd_val   = '0;

    if (core_q.arm) begin
      if (core_q.arm_cnt == ARM_CYC - 3'h1) begin
        core_d.arm = 1'b0;
      end else begin
        core_d.arm_cnt = core_q.arm_cnt + 3'h1;
      end
    end
    if (core_q.rd_pend) begin
      core_d.eedata  = ee_rdata;
      core_d.rd_pend = 1'b0;
    end

    unique case (core_q.st)
      ST_IDLE: begin
        if (req) begin
          core_d.st     = ST_EXEC;
          core_d.op     = op_in;
          core_d.addr   = eff_addr;
          core_d.sel    = dec_sel;
          core_d.sofs   = dec_ofs;
          core_d.intern = hit_int;
          core_d.wdata  = req_wdata;
          core_d.wmask  = BYTE_FULL;
          if (op_in == OP_SETBIT) begin
            core_d.wdata = mask;
            core_d.wmask = mask;
          end else if (op_in == OP_CLRBIT) begin
            core_d.wdata = '0;
            core_d.wmask = mask;
          end else if (!is_wr) begin
            core_d.wmask = mask;
          end
          core_d.ext_we = is_wr && !hit_int && (dec_sel != '0);
          core_d.ext_re = !is_wr && !hit_int && (dec_sel != '0);
          if ((op_in == OP_LOAD) || (op_in == OP_STORE)) begin
            if (am_in == AM_PREDEC) begin
              core_d.ptr[pidx] = pval - PTR_STEP;
            end else if (am_in == AM_POSTINC) begin
              core_d.ptr[pidx] = pval + PTR_STEP;
            end
          end
        end
      end
      ST_EXEC: begin
        core_d.st = ST_FIN;
        if (op_writes(core_q.op) && core_q.intern) begin
          if (core_q.sel[SEL_RF]) begin
            if (ridx[0]) begin
              core_d.ptr[ridx[2:1]][15:8] = core_q.wdata;
            end else begin
              core_d.ptr[ridx[2:1]][7:0] = core_q.wdata;
            end
          end else if (core_q.addr == EE_CTL_DA) begin
            ctl_wr   = 1'b1;
            ctl_data = core_q.wdata;
            ctl_mask = core_q.wmask;
            if (ctl_mask[CTL_WR_BIT] && ctl_data[CTL_WR_BIT] && core_q.arm &&
                !eng_q.busy && (eng_q.mode != MODE_RSVD)) begin
              ee_start     = 1'b1;
              core_d.stall = WR_STALL;
            end else if (ctl_mask[CTL_RD_BIT] && ctl_data[CTL_RD_BIT] && !eng_q.busy) begin
              core_d.rd_pend = 1'b1;
              core_d.stall   = RD_STALL;
            end
            if (ctl_mask[CTL_ARM_BIT] && ctl_data[CTL_ARM_BIT]) begin
              core_d.arm     = 1'b1;
              core_d.arm_cnt = '0;
            end
          end else if (core_q.addr == EE_DATA_DA) begin
            core_d.eedata = merge_byte(core_q.eedata, core_q.wdata, core_q.wmask);
          end else if (!eng_q.busy) begin
            if (core_q.addr == EE_ADRL_DA) begin
              core_d.eeadr[7:0] = merge_byte(core_q.eeadr[7:0], core_q.wdata, core_q.wmask);
            end else begin
              core_d.eeadr[11:8] = hi_byte[3:0];
            end
          end
        end
      end
      ST_FIN: begin
        if (core_q.intern) begin
          if (core_q.sel[SEL_RF]) begin
            rd_val = ridx[0] ? core_q.ptr[ridx[2:1]][15:8] : core_q.ptr[ridx[2:1]][7:0];
          end else if (core_q.addr == EE_CTL_DA) begin
            rd_val = ctl_rd;
          end else if (core_q.addr == EE_DATA_DA) begin
            rd_val = core_q.eedata;
          end else if (core_q.addr == EE_ADRL_DA) begin
            rd_val = core_q.eeadr[7:0];
          end else begin
            rd_val = {4'h0, core_q.eeadr[11:8]};
          end
        end else if (core_q.sel[SEL_SRAM]) begin
          rd_val = sram_rdata;
        end else if (core_q.sel != '0) begin
          rd_val = ext_rdata;
        end
        if (!op_writes(core_q.op)) begin
          core_d.rdata = rd_val;
        end
        core_d.skip = ((core_q.op == OP_SKIPSET) && ((rd_val & core_q.wmask) != '0)) ||
                      ((core_q.op == OP_SKIPCLR) && ((rd_val & core_q.wmask) == '0));
        if (core_q.stall != '0) begin
          core_d.st = ST_STALL;
        end else begin
          core_d.st   = ST_IDLE;
          core_d.done = 1'b1;
        end
      end
      ST_STALL: begin
        core_d.stall = core_q.stall - 3'h1;
        if (core_q.stall == 3'h1) begin
          core_d.st   = ST_IDLE;
          core_d.done = 1'b1;
        end
      end
    endcase

    // The program counter holds while busy.
    if (!core_q.busy) begin
      if (pc_load) begin
        core_d.pc = pc_target;
      end else if (pc_step) begin
        core_d.pc = core_q.pc + PTR_STEP;
      end
    end
    core_d.busy = (core_d.st != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_q <= '0;
    end else begin
      core_q <= core_d;
    end
  end

  assign sram_we = (core_q.st == ST_EXEC) && core_q.sel[SEL_SRAM] && op_writes(core_q.op);

  dsee_mem #(
    .AW (SRAM_AW),
    .DW (8)
  ) u_sram (
    .clk     (clk),
    .rstn    (rstn),
    .addr    (core_q.sofs),
    .we      (sram_we),
    .wdata   (core_q.wdata),
    .rdata_q (sram_rdata)
  );

  // ******************************************************************
  // EEPROM write engine
  // ******************************************************************
  always_comb begin
    eng_d = eng_q;
    ee_we = 1'b0;
    if (eng_q.busy) begin
      if (eng_q.timer == TIMER_LAST) begin
        eng_d.busy = 1'b0;
        ee_we      = 1'b1;
      end else begin
        eng_d.timer = eng_q.timer - TIMER_LAST;
      end
    end else if (ee_start) begin
      eng_d.busy  = 1'b1;
      eng_d.waddr = core_q.eeadr;
      eng_d.wdata = core_q.eedata;
      eng_d.timer = (eng_q.mode == MODE_EW) ? TW'(EW_CYCLES) : TW'(ERW_CYCLES);
    end else if (ctl_wr) begin
      eng_d.mode = dsee_pmode_t'(merge_byte({6'h00, eng_q.mode},
                                            {6'h00, ctl_data[CTL_MODE_HI:CTL_MODE_LO]},
                                            {6'h00, ctl_mask[CTL_MODE_HI:CTL_MODE_LO]}));
    end
  end

  always_comb begin
    unique case (eng_q.mode)
      MODE_EW:    ee_wbyte = eng_q.wdata;
      MODE_ERASE: ee_wbyte = ERASED;
      MODE_WRITE: ee_wbyte = ee_rdata & eng_q.wdata;
      MODE_RSVD:  ee_wbyte = ee_rdata;
    endcase
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      eng_q <= '0;
    end else begin
      eng_q <= eng_d;
    end
  end

  assign ee_addr = eng_q.busy ? eng_q.waddr : core_q.eeadr;

  dsee_mem #(
    .AW (EE_AW),
    .DW (8)
  ) u_eeprom (
    .clk     (clk),
    .rstn    (rstn),
    .addr    (ee_addr),
    .we      (ee_we),
    .wdata   (ee_wbyte),
    .rdata_q (ee_rdata)
  );

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign busy_q            = core_q.busy;
  assign done_q            = core_q.done;
  assign rdata_q           = core_q.rdata;
  assign skip_q            = core_q.skip;
  assign sel_q             = core_q.sel;
  assign ext_re_q          = core_q.ext_re;
  assign ext_we_q          = core_q.ext_we;
  assign ext_addr_q        = core_q.addr[7:0];
  assign ext_wdata_q       = core_q.wdata;
  assign ext_wmask_q       = core_q.wmask;
  assign nv_write_strobe_q = eng_q.busy;
  assign program_counter_q = core_q.pc;

endmodule // dsee_port

`default_nettype wire

// >>> dsee_properties.sv
// Assertions for the decode and EEPROM port.
`default_nettype none
module dsee_chk
  import dsee_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        por_n,
  input wire logic        req,
  input wire logic        busy_q,
  input wire logic        done_q,
  input wire logic [2:0]  req_op,
  input wire logic [2:0]  req_mode,
  input wire logic [15:0] req_addr,
  input wire logic [5:0]  req_io,
  input wire logic [7:0]  req_wdata,
  input wire logic        pc_step,
  input wire logic        pc_load,
  input wire logic [3:0]  sel_q,
  input wire logic        ext_we_q,
  input wire logic [7:0]  ext_wmask_q,
  input wire logic        nv_write_strobe_q,
  input wire logic [15:0] program_counter_q
);
  // ********************************************************************
  // Properties
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    req && !busy_q;
  endsequence
  a_sram_two: assert property (s_take ##0 (req_op == 3'h0 && req_mode == 3'h0
    && req_addr >= 16'h0100 && req_addr < 16'h1100) |=> busy_q [*2] ##1 (done_q && sel_q == 4'h8))
    else $error("sram access time or select wrong");
  a_ee_stall: assert property (s_take ##0 (req_op == 3'h3 && req_io == 6'h1F
    && req_wdata == 8'h01 && !nv_write_strobe_q) |=> busy_q [*6] ##1 done_q)
    else $error("eeprom read stall wrong");
  a_io_no_ext: assert property (s_take ##0 (req_op inside {3'h2, 3'h3}) |=> ##1 !sel_q[2])
    else $error("in or out reached extended io");
  a_done_end: assert property ($fell(busy_q) |-> done_q ##1 !done_q)
    else $error("done not a single pulse at end");
  a_sel_onehot: assert property (done_q |-> $onehot0(sel_q))
    else $error("more than one target select");
  a_mask_bit: assert property (ext_we_q |-> ext_wmask_q == 8'hFF || $onehot(ext_wmask_q))
    else $error("write mask neither full nor one bit");
  a_pc_step: assert property (pc_step && !pc_load && !busy_q |=>
    program_counter_q == $past(program_counter_q) + 16'h0001) else $error("pc step wrong");
  a_wr_hold: assert property (disable iff (!por_n)
    $rose(nv_write_strobe_q) |-> nv_write_strobe_q [*8]) else $error("write ended early");
endmodule // dsee_chk
bind dsee_port dsee_chk u_dsee_chk (.*);
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the decode and EEPROM port.
`default_nettype none
module testbench
  import dsee_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rstn = 1'b0, por_n = 1'b0, req = 1'b0, pc_step = 1'b0, pc_load = 1'b0;
  logic [2:0]  req_op = 3'h0, req_mode = 3'h0, req_bit = 3'h0;
  logic [1:0]  req_ptr = 2'h0;
  logic [5:0]  req_disp = 6'h00, req_io = 6'h00;
  logic [15:0] req_addr = 16'h0000, pc_target = 16'h0000, program_counter_q;
  logic [7:0]  req_wdata = 8'h00, ext_rdata, rdata_q, ext_addr_q, ext_wdata_q, ext_wmask_q;
  logic        busy_q, done_q, skip_q, ext_re_q, ext_we_q, nv_write_strobe_q;
  logic [3:0]  sel_q;
  int          n_errors = 0, tests_run = 0, lat = 0, cyc = 0;
  dsee_port #(.EW_CYCLES(20), .ERW_CYCLES(10)) u_dsee_port (.*);
  dsee_ext_model u_dsee_ext_model (.*);
  // ********************************************************************
  // Helpers
  // ********************************************************************
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic ck(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Runs from a falling edge to the falling edge of the done cycle.
  task automatic ac(input logic [2:0] o, input logic [2:0] m, input logic [15:0] a,
                    input logic [7:0] w);
    req = 1'b1; req_op = o; req_mode = m; req_bit = m; req_addr = a; req_wdata = w;
    req_io = a[5:0]; req_ptr = a[15:14]; req_disp = a[13:8];
    @(negedge clk);
    req = 1'b0;
    lat = 1;
    while (done_q !== 1'b1 && lat < 12) begin
      @(negedge clk);
      lat++;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ee_rd(input logic [15:0] e);
    ac(OP_OUT, 3'h0, 16'h001F, 8'h01);
    ck("rd_lat", 16'h0007, lat);
    ac(OP_IN, 3'h0, 16'h0020, 8'h00);
    ck("ee_data", e, rdata_q);
  endtask
  task automatic ee_wr(input logic [1:0] md, input logic rs);
    int w;
    ac(OP_OUT, 3'h0, 16'h001F, {2'b00, md, 4'h0});
    ac(OP_SETBIT, 3'h2, 16'h001F, 8'h00);
    ac(OP_SETBIT, 3'h1, 16'h001F, 8'h00);
    ck("wr_lat", (md == 2'b11) ? 16'h0003 : 16'h0005, lat);
    ck("wr_busy", {15'h0, md != 2'b11}, nv_write_strobe_q);
    if (rs) begin
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
    end else begin
      ac(OP_OUT, 3'h0, 16'h0021, 8'h77);
      ac(OP_IN, 3'h0, 16'h0021, 8'h00);
      ck("addr_lock", 16'h0034, rdata_q);
    end
    w = 0;
    while (nv_write_strobe_q === 1'b1 && w < 100) begin
      @(negedge clk);
      w++;
    end
    ck("wr_end", 16'h0000, nv_write_strobe_q);
  endtask
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_map();
    logic [15:0] ad [9] = '{16'h0005, 16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF,
                            16'h0100, 16'h10FF, 16'h1100};
    logic [3:0]  ex [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h0};
    foreach (ad[i]) begin
      ac(OP_LOAD, 3'h0, ad[i], 8'h00);
      ck("sel", {12'h000, ex[i]}, {12'h000, sel_q});
      ck("lat", 16'h0003, lat);
    end
    $display("t_map done");
  endtask
  task automatic t_io();
    ac(OP_OUT, 3'h0, 16'h0005, 8'h3C);
    ac(OP_LOAD, 3'h0, 16'h0025, 8'h00);
    ck("io_alias", 16'h003C, rdata_q);
    ac(OP_SETBIT, 3'h0, 16'h0005, 8'h00);
    ac(OP_CLRBIT, 3'h2, 16'h0005, 8'h00);
    ac(OP_IN, 3'h0, 16'h0005, 8'h00);
    ck("bit_ops", 16'h0039, rdata_q);
    ac(OP_SKIPCLR, 3'h1, 16'h0005, 8'h00);
    ck("skip", 16'h0001, skip_q);
    ac(OP_SETBIT, 3'h0, 16'h000E, 8'h00);
    ac(OP_IN, 3'h0, 16'h000E, 8'h00);
    ck("flag_kept", 16'h0081, rdata_q);
    ac(OP_OUT, 3'h0, 16'h000E, 8'h80);
    ac(OP_IN, 3'h0, 16'h000E, 8'h00);
    ck("flag_clr", 16'h0000, rdata_q);
    $display("t_io done");
  endtask
  task automatic t_ptr();
    ac(OP_STORE, 3'h0, 16'h0160, 8'hAA);
    ac(OP_STORE, 3'h0, 16'h0161, 8'hBB);
    ac(OP_STORE, 3'h0, 16'h001A, 8'h60);
    ac(OP_STORE, 3'h0, 16'h001B, 8'h01);
    ac(OP_STORE, 3'h0, 16'h001E, 8'h50);
    ac(OP_STORE, 3'h0, 16'h001F, 8'h01);
    ac(OP_LOAD, AM_POSTINC, 16'h0000, 8'h00);
    ck("postinc", 16'h00AA, rdata_q);
    ac(OP_LOAD, AM_PREDEC, 16'h0000, 8'h00);
    ck("predec", 16'h00AA, rdata_q);
    ac(OP_LOAD, AM_DISP, 16'h9100, 8'h00);
    ck("disp", 16'h00BB, rdata_q);
    $display("t_ptr done");
  endtask
  task automatic t_ee();
    ac(OP_OUT, 3'h0, 16'h0021, 8'h34);
    ac(OP_OUT, 3'h0, 16'h0022, 8'hFF);
    ac(OP_IN, 3'h0, 16'h0022, 8'h00);
    ck("addr_hi", 16'h000F, rdata_q);
    ac(OP_OUT, 3'h0, 16'h0020, 8'h5A);
    ac(OP_SETBIT, 3'h1, 16'h001F, 8'h00);
    ck("no_arm", 16'h0000, nv_write_strobe_q);
    ee_wr(2'b00, 1'b1);
    ac(OP_OUT, 3'h0, 16'h0021, 8'h34);
    ac(OP_OUT, 3'h0, 16'h0022, 8'h0F);
    ee_rd(16'h005A);
    ee_wr(2'b01, 1'b0);
    ee_rd(16'h00FF);
    ac(OP_SETBIT, 3'h2, 16'h001F, 8'h00);
    repeat (4) @(negedge clk);
    ac(OP_SETBIT, 3'h1, 16'h001F, 8'h00);
    ck("arm_late", 16'h0000, nv_write_strobe_q);
    ee_wr(2'b11, 1'b1);
    $display("t_ee done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    por_n = 1'b1;
    t_map();
    t_io();
    t_ptr();
    t_ee();
    pc_load = 1'b1;
    pc_target = 16'hFFFF;
    @(negedge clk);
    pc_load = 1'b0;
    pc_step = 1'b1;
    @(negedge clk);
    pc_step = 1'b0;
    ck("pc_wrap", 16'h0000, program_counter_q);
    $display("t_pc done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
